//--- design/iwdt_map.svh
// Register map, field positions, reset values and timing figures of the watchdog
// Assumes inclusion by bare name from the top module and the property checker
`ifndef IWDT_MAP_SVH
`define IWDT_MAP_SVH

// ----------------------------------------------------------------
// I/O ports and lock key
// ----------------------------------------------------------------
`define IWDT_PORT_INDEX     16'h0022
`define IWDT_PORT_DATA      16'h0023
`define IWDT_IDX_LOCK       8'h13
`define IWDT_UNLOCK_KEY     8'hc5

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define IWDT_IDX_ENABLE     8'h37
`define IWDT_IDX_REPORT     8'h38
`define IWDT_IDX_CNT_LO     8'h39
`define IWDT_IDX_CNT_MID    8'h3a
`define IWDT_IDX_CNT_HI     8'h3b
`define IWDT_IDX_STATUS     8'h3c

// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define IWDT_EN_BIT         6
`define IWDT_SEL_MSB        7
`define IWDT_SEL_LSB        4
`define IWDT_SEL_IRQ_FIRST  4'h1
`define IWDT_SEL_IRQ_LAST   4'hb
`define IWDT_SEL_NMI        4'hc
`define IWDT_SEL_RST        4'hd
`define IWDT_NUM_IRQ        11
`define IWDT_ST_TO_BIT      7
`define IWDT_ST_RESTART_BIT 5
`define IWDT_ST_KEEP_MASK   8'h5f

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define IWDT_BYTE_RST       8'h00
`define IWDT_COUNT_RST      24'hffffff
`define IWDT_INDEX_RST      8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define IWDT_CLK_PERIOD_NS  8.0
`define IWDT_TICK_PERIOD_US 30.5
`define IWDT_NS_PER_US      1000.0
`define IWDT_REPORT_PULSE   16

`endif

//--- design/iwdt_pkg.sv
// Types shared by the watchdog modules
// Assumes the map header supplies all numeric constants
package iwdt_pkg;

  // Counter state
  typedef enum logic [0:0] {
    iwdt_off,
    iwdt_count
  } iwdt_state_t;

  // Kind of report latched at expiry
  typedef enum logic [1:0] {
    iwdt_rpt_none,
    iwdt_rpt_irq,
    iwdt_rpt_nmi,
    iwdt_rpt_reset
  } iwdt_report_t;

endpackage

//--- design/iwdt_tick_div.sv
// Prescaler that turns the system clock into a one-cycle tick enable
// Assumes a synchronous active-low reset already released cleanly
`timescale 1ns/1ps
module iwdt_tick_div #(
  parameter int TICK_CYC = 3813
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic clear,
  input  wire logic run,
  output logic      tick
);

  localparam int CW = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
  localparam logic [CW-1:0] LAST = CW'(TICK_CYC - 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  // Wrap at the last cycle, restart on clear
  always_comb begin
    tick  = run && !clear && (cnt_q == LAST);
    cnt_d = cnt_q;
    if (clear || !run) begin
      cnt_d = '0;
    end else if (cnt_q == LAST) begin
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + CW'(1);
    end
  end

  // Register the prescale count
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

//--- design/iwdt_top.sv
// Indexed watchdog timer: lock, index/data ports, registers, down-counter, reports
// Assumes host I/O strobes synchronous to mclk, one cycle each
`include "iwdt_map.svh"
`timescale 1ns/1ps
module iwdt_top #(
  parameter int TICK_CYC  = int'($ceil(`IWDT_TICK_PERIOD_US * `IWDT_NS_PER_US / `IWDT_CLK_PERIOD_NS)),
  parameter int PULSE_CYC = `IWDT_REPORT_PULSE
) (
  input  wire logic                     mclk,
  input  wire logic                     rst_b,
  input  wire logic [15:0]              io_addr,
  input  wire logic                     io_wr,
  input  wire logic                     io_rd,
  input  wire logic [7:0]               io_wdata,
  output logic      [7:0]               io_rdata,
  output logic      [`IWDT_NUM_IRQ-1:0] irq_out,
  output logic                          nmi_out,
  output logic                          sys_reset_out,
  output logic                          running
);

  localparam int PW = $clog2(PULSE_CYC + 1);
  localparam logic [PW-1:0] PULSE_LOAD = PW'(PULSE_CYC);
  localparam logic [23:0] ONE_COUNT = 24'h000001;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_q;
  logic rst_n;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_n = rst_sync_q;

  // ----------------------------------------------------------------
  // Host port decode
  // ----------------------------------------------------------------
  logic       idx_wr;
  logic       data_wr;
  logic       cfg_wr;
  logic       restart_req;

  logic [7:0] index_q;
  logic [7:0] index_d;
  logic       unlocked_q;
  logic       unlocked_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  logic [7:0]  enable_q;
  logic [7:0]  enable_d;
  logic [7:0]  report_q;
  logic [7:0]  report_d;
  logic [23:0] reload_q;
  logic [23:0] reload_d;
  logic [7:0]  keep_q;
  logic [7:0]  keep_d;
  logic        timeout_q;
  logic        timeout_d;
  logic [7:0]  status_rd;

  // Strobes for the two ports and for unlocked data writes
  always_comb begin
    idx_wr      = io_wr && (io_addr == `IWDT_PORT_INDEX);
    data_wr     = io_wr && (io_addr == `IWDT_PORT_DATA);
    cfg_wr      = data_wr && unlocked_q;
    restart_req = cfg_wr && (index_q == `IWDT_IDX_STATUS) && io_wdata[`IWDT_ST_RESTART_BIT];
  end

  // Status byte as read: sticky flag, restart bit reads zero
  always_comb begin
    status_rd = keep_q & `IWDT_ST_KEEP_MASK;
    status_rd[`IWDT_ST_TO_BIT] = timeout_q;
  end

  // ----------------------------------------------------------------
  // Index, lock and read path
  // ----------------------------------------------------------------

  // Index latch, lock key and read mux
  always_comb begin
    index_d    = index_q;
    unlocked_d = unlocked_q;
    rdata_d    = rdata_q;
    if (idx_wr) begin
      index_d = io_wdata;
    end
    // Key value opens access, any other value at that index closes it
    if (data_wr && (index_q == `IWDT_IDX_LOCK)) begin
      unlocked_d = (io_wdata == `IWDT_UNLOCK_KEY);
    end
    if (io_rd) begin
      rdata_d = `IWDT_BYTE_RST;
      if (io_addr == `IWDT_PORT_INDEX) begin
        rdata_d = index_q;
      end else if (io_addr == `IWDT_PORT_DATA) begin
        unique case (index_q)
          `IWDT_IDX_LOCK:    rdata_d = unlocked_q ? `IWDT_UNLOCK_KEY : `IWDT_BYTE_RST;
          `IWDT_IDX_ENABLE:  rdata_d = enable_q;
          `IWDT_IDX_REPORT:  rdata_d = report_q;
          `IWDT_IDX_CNT_LO:  rdata_d = reload_q[7:0];
          `IWDT_IDX_CNT_MID: rdata_d = reload_q[15:8];
          `IWDT_IDX_CNT_HI:  rdata_d = reload_q[23:16];
          `IWDT_IDX_STATUS:  rdata_d = status_rd;
          default:           rdata_d = `IWDT_BYTE_RST;
        endcase
      end
    end
  end

  // Register index, lock and read data
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      index_q    <= `IWDT_INDEX_RST;
      unlocked_q <= 1'b0;
      rdata_q    <= `IWDT_BYTE_RST;
    end else begin
      index_q    <= index_d;
      unlocked_q <= unlocked_d;
      rdata_q    <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------

  // Byte writes through the data port while unlocked
  always_comb begin
    enable_d = enable_q;
    report_d = report_q;
    reload_d = reload_q;
    keep_d   = keep_q;
    if (cfg_wr) begin
      unique case (index_q)
        `IWDT_IDX_ENABLE:  enable_d = io_wdata;
        `IWDT_IDX_REPORT:  report_d = io_wdata;
        `IWDT_IDX_CNT_LO:  reload_d[7:0] = io_wdata;
        `IWDT_IDX_CNT_MID: reload_d[15:8] = io_wdata;
        `IWDT_IDX_CNT_HI:  reload_d[23:16] = io_wdata;
        `IWDT_IDX_STATUS:  keep_d = io_wdata & `IWDT_ST_KEEP_MASK;
        default: begin
        end
      endcase
    end
  end

  // Register configuration; watchdog comes up disabled
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      enable_q <= `IWDT_BYTE_RST;
      report_q <= `IWDT_BYTE_RST;
      reload_q <= `IWDT_COUNT_RST;
      keep_q   <= `IWDT_BYTE_RST;
    end else begin
      enable_q <= enable_d;
      report_q <= report_d;
      reload_q <= reload_d;
      keep_q   <= keep_d;
    end
  end

  // ----------------------------------------------------------------
  // Tick prescaler
  // ----------------------------------------------------------------
  iwdt_pkg::iwdt_state_t state_q;
  iwdt_pkg::iwdt_state_t state_d;
  logic        tick;
  logic        tick_clr;
  logic        start;
  logic        expire;
  logic        wd_on;
  logic [23:0] count_q;
  logic [23:0] count_d;

  assign wd_on = enable_q[`IWDT_EN_BIT];

  iwdt_tick_div #(
    .TICK_CYC (TICK_CYC)
  ) u_tick_div (
    .mclk  (mclk),
    .rst_n (rst_n),
    .clear (tick_clr),
    .run   (state_q == iwdt_pkg::iwdt_count),
    .tick  (tick)
  );

  // ----------------------------------------------------------------
  // Down-counter
  // ----------------------------------------------------------------

  // Load on enable or trigger, count ticks, expire on the last one
  always_comb begin
    state_d  = state_q;
    count_d  = count_q;
    start    = 1'b0;
    expire   = 1'b0;
    tick_clr = 1'b0;
    unique case (state_q)
      iwdt_pkg::iwdt_off: begin
        if (wd_on) begin
          start   = 1'b1;
          state_d = iwdt_pkg::iwdt_count;
          count_d = reload_q;
        end
      end
      iwdt_pkg::iwdt_count: begin
        if (!wd_on) begin
          state_d = iwdt_pkg::iwdt_off;
        end else if (restart_req) begin
          count_d  = reload_q;
          tick_clr = 1'b1;
        end else if (tick) begin
          // One count unit per tick, zero expires at the first tick
          if (count_q <= ONE_COUNT) begin
            expire  = 1'b1;
            count_d = reload_q;
          end else begin
            count_d = count_q - ONE_COUNT;
          end
        end
      end
    endcase
  end

  // Register counter state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= iwdt_pkg::iwdt_off;
      count_q <= `IWDT_COUNT_RST;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
    end
  end

  // ----------------------------------------------------------------
  // Timeout flag and report outputs
  // ----------------------------------------------------------------
  iwdt_pkg::iwdt_report_t kind_q;
  iwdt_pkg::iwdt_report_t kind_d;
  logic [3:0]               sel_q;
  logic [3:0]               sel_d;
  logic [3:0]               sel_now;
  logic [PW-1:0]            pulse_q;
  logic [PW-1:0]            pulse_d;
  logic [`IWDT_NUM_IRQ-1:0] irq_d;
  logic [`IWDT_NUM_IRQ-1:0] irq_q;
  logic                     nmi_d;
  logic                     nmi_q;
  logic                     sysrst_d;
  logic                     sysrst_q;
  logic                     running_q;

  assign sel_now = report_q[`IWDT_SEL_MSB:`IWDT_SEL_LSB];

  // Sticky flag, report latch and pulse stretch
  always_comb begin
    timeout_d = timeout_q;
    kind_d    = kind_q;
    sel_d     = sel_q;
    pulse_d   = pulse_q;
    // Restart clears the flag, a restart on the last tick wins and no expiry occurs
    if (restart_req) begin
      timeout_d = 1'b0;
    end
    if (expire) begin
      timeout_d = 1'b1;
      sel_d     = sel_now;
      pulse_d   = PULSE_LOAD;
      if (sel_now == `IWDT_SEL_NMI) begin
        kind_d = iwdt_pkg::iwdt_rpt_nmi;
      end else if (sel_now == `IWDT_SEL_RST) begin
        kind_d = iwdt_pkg::iwdt_rpt_reset;
      end else if (sel_now >= `IWDT_SEL_IRQ_FIRST && sel_now <= `IWDT_SEL_IRQ_LAST) begin
        kind_d = iwdt_pkg::iwdt_rpt_irq;
      end else begin
        kind_d = iwdt_pkg::iwdt_rpt_none;
      end
    end else if (pulse_q != '0) begin
      pulse_d = pulse_q - PW'(1);
    end
    irq_d    = '0;
    nmi_d    = 1'b0;
    sysrst_d = 1'b0;
    if (pulse_d != '0) begin
      unique case (kind_d)
        iwdt_pkg::iwdt_rpt_irq:   irq_d = `IWDT_NUM_IRQ'(1) << (sel_d - `IWDT_SEL_IRQ_FIRST);
        iwdt_pkg::iwdt_rpt_nmi:   nmi_d = 1'b1;
        iwdt_pkg::iwdt_rpt_reset: sysrst_d = 1'b1;
        iwdt_pkg::iwdt_rpt_none: begin
        end
      endcase
    end
  end

  // Register flag and report outputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timeout_q <= 1'b0;
      kind_q    <= iwdt_pkg::iwdt_rpt_none;
      sel_q     <= 4'h0;
      pulse_q   <= '0;
      irq_q     <= '0;
      nmi_q     <= 1'b0;
      sysrst_q  <= 1'b0;
      running_q <= 1'b0;
    end else begin
      timeout_q <= timeout_d;
      kind_q    <= kind_d;
      sel_q     <= sel_d;
      pulse_q   <= pulse_d;
      irq_q     <= irq_d;
      nmi_q     <= nmi_d;
      sysrst_q  <= sysrst_d;
      running_q <= (state_d == iwdt_pkg::iwdt_count);
    end
  end

  // Outputs straight from flops
  assign io_rdata      = rdata_q;
  assign irq_out       = irq_q;
  assign nmi_out       = nmi_q;
  assign sys_reset_out = sysrst_q;
  assign running       = running_q;

endmodule

//--- test/iwdt_properties.sv
// Port checker for the watchdog top
// Assumes it is bound into iwdt_top and sees only its ports
`include "iwdt_map.svh"
`timescale 1ns/1ps
module iwdt_properties #(
  parameter int TICK_CYC  = 4,
  parameter int PULSE_CYC = 2
) (
  input wire logic                     mclk,
  input wire logic                     rst_b,
  input wire logic [15:0]              io_addr,
  input wire logic                     io_wr,
  input wire logic                     io_rd,
  input wire logic [7:0]               io_wdata,
  input wire logic [7:0]               io_rdata,
  input wire logic [`IWDT_NUM_IRQ-1:0] irq_out,
  input wire logic                     nmi_out,
  input wire logic                     sys_reset_out,
  input wire logic                     running
);
  logic [7:0]  idx_q, idx_d, pc_q, pc_d;
  logic        unl_q, unl_d, rep, dwr, enw, enb;
  logic [15:0] rc_q, rc_d;
  // Any report line, data port write
  assign rep = |{irq_out, nmi_out, sys_reset_out};
  assign dwr = io_wr && io_addr == 16'h0023;
  // Unlocked enable write and its enable bit; running follows two edges later
  assign enw = dwr && idx_q == 8'h37 && unl_q;
  assign enb = io_wdata[6];
  // Mirror of index and lock, pulse length, cycles spent running
  always_comb begin
    idx_d = (io_wr && io_addr == 16'h0022) ? io_wdata : idx_q;
    unl_d = (dwr && idx_q == 8'h13) ? io_wdata == 8'hc5 : unl_q;
    pc_d  = rep ? pc_q + 8'h01 : 8'h00;
    rc_d  = !running ? 16'h0000 : (&rc_q ? rc_q : rc_q + 16'h0001);
  end
  // Registers of the mirror
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      idx_q <= 8'h00;
      unl_q <= 1'b0;
      pc_q  <= 8'h00;
      rc_q  <= 16'h0000;
    end else begin
      idx_q <= idx_d;
      unl_q <= unl_d;
      pc_q  <= pc_d;
      rc_q  <= rc_d;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_rdata_hold: assert property (!io_rd |=> $stable(io_rdata))
    else $error("read data moved without a read");
  a_one_report: assert property ($onehot0({irq_out, nmi_out, sys_reset_out}))
    else $error("two report kinds at once");
  a_pulse_max: assert property (int'(pc_q) <= PULSE_CYC)
    else $error("report pulse too long");
  a_pulse_full: assert property ($fell(rep) |-> int'(pc_q) == PULSE_CYC)
    else $error("report pulse too short");
  a_report_armed: assert property ($rose(rep) |-> $past(running) && int'(rc_q) >= TICK_CYC)
    else $error("report without a full tick of running");
  a_run_cause: assert property ($changed(running) |->
    $past(enw, 2) && ($past(enb, 2) == running))
    else $error("running changed without an unlocked enable write");
  a_lock_read: assert property (io_rd && io_addr == 16'h0023 && idx_q == 8'h13 |=>
    io_rdata == ($past(unl_q) ? 8'hc5 : 8'h00))
    else $error("lock index reads wrong");
  a_restart_bit: assert property (io_rd && io_addr == 16'h0023 && idx_q == 8'h3c |=> !io_rdata[5])
    else $error("restart bit reads one");
  c_nmi: cover property ($rose(nmi_out));
  c_reset: cover property ($rose(sys_reset_out));
  c_restart: cover property (dwr && idx_q == 8'h3c && io_wdata[5] && running);
endmodule

bind iwdt_top iwdt_properties #(.TICK_CYC(TICK_CYC), .PULSE_CYC(PULSE_CYC)) chk_i (
  .mclk(mclk), .rst_b(rst_b), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
  .io_wdata(io_wdata), .io_rdata(io_rdata), .irq_out(irq_out), .nmi_out(nmi_out),
  .sys_reset_out(sys_reset_out), .running(running));

//--- test/iwdt_host.sv
// Host processor model: one I/O cycle at a time on the index and data ports
// Assumes the bench calls its tasks only after reset is released
`timescale 1ns/1ps
module iwdt_host (
  input  wire logic        mclk,
  output logic      [15:0] io_addr,
  output logic             io_wr,
  output logic             io_rd,
  output logic      [7:0]  io_wdata,
  input  wire logic [7:0]  io_rdata
);
  realtime t_take;
  int      gap = 0;
  initial begin
    io_addr  = 16'h0000;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    io_wdata = 8'h00;
  end
  // One strobe; idle gap makes a slow host, released lines are scrambled
  task automatic cyc(input logic [15:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
    repeat (gap) @(posedge mclk);
    @(posedge mclk);
    io_addr  <= a;
    io_wr    <= w;
    io_rd    <= !w;
    io_wdata <= d;
    @(posedge mclk);
    t_take = $realtime;
    io_wr    <= 1'b0;
    io_rd    <= 1'b0;
    io_addr  <= ~a;
    io_wdata <= ~d;
    #1 q = io_rdata;
  endtask
  // Index to the index port, then the data port
  task automatic reg_acc(input logic [7:0] idx, input logic w, input logic [7:0] d, output logic [7:0] q);
    logic [7:0] u;
    cyc(16'h0022, 1'b1, idx, u);
    cyc(16'h0023, w, d, q);
  endtask
endmodule

//--- test/tb.sv
// Self-checking bench for the watchdog, with an integer register model
// Assumes the host model drives all port accesses
`timescale 1ns/1ps
module tb;
  localparam int TICK  = 4;
  localparam int PULSE = 2;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic [15:0] io_addr;
  logic        io_wr, io_rd, nmi_out, sys_reset_out, running;
  logic [7:0]  io_wdata, io_rdata, q;
  logic [10:0] irq_out;
  int          mismatches = 0;
  int          checks_done = 0;
  int          cyc_n = 0;
  int          unl = 0;
  int          flag = 0;
  int          regs [int];
  realtime     t0;
  iwdt_top #(.TICK_CYC(TICK), .PULSE_CYC(PULSE)) uut (
    .mclk(mclk), .rst_b(rst_b), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .irq_out(irq_out), .nmi_out(nmi_out),
    .sys_reset_out(sys_reset_out), .running(running));
  iwdt_host h (
    .mclk(mclk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata));
  // Clock
  initial begin
    forever #4 mclk = ~mclk;
  end
  // Hang guard
  always @(posedge mclk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic chk(input string n, input logic [12:0] e, input logic [12:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Read through the ports and compare with the model
  task automatic rd(input int i, input string n);
    int e;
    e = i == 'h13 ? (unl ? 'hc5 : 0) : i == 'h3c ? (regs[i] & 'h5f) | (flag << 7) : regs.exists(i) ? regs[i] : 0;
    h.reg_acc(8'(i), 1'b0, 8'h00, q);
    chk(n, 13'(e), {5'h00, q});
  endtask
  // Write through the ports and update the model
  task automatic wr(input int i, input int d);
    h.reg_acc(8'(i), 1'b1, 8'(d), q);
    if (i == 'h13) unl = d == 'hc5;
    else if (unl && regs.exists(i)) begin
      if (i == 'h3c && d[5]) flag = 0;
      regs[i] = d;
    end
  endtask
  // Wait for expiry counted from t0, check kind and delay; ld is the load lag in edges
  task automatic expect_rep(input int n, input int s, input int ld, input string nm);
    int e;
    n = n == 0 ? 1 : n;
    e = (s >= 1 && s <= 11) ? 1 << (s + 1) : s == 12 ? 2 : s == 13 ? 1 : 0;
    while ({irq_out, nmi_out, sys_reset_out} === 13'h0 && $realtime < t0 + (n * TICK + 3) * 8) begin
      @(posedge mclk);
      #1;
    end
    chk(nm, 13'(e), {irq_out, nmi_out, sys_reset_out});
    if (e != 0) chk("expiry delay", 13'(n * TICK + ld), 13'(int'(($realtime - t0 - 1) / 8)));
    flag = 1;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'h3c372d96));
    regs = '{'h37: 0, 'h38: 0, 'h39: 'hff, 'h3a: 'hff, 'h3b: 'hff, 'h3c: 0};
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    foreach (regs[i]) rd(i, "reset value");
    rd('h40, "unmapped index");
    h.cyc(16'h0080, 1'b0, 8'h00, q);
    chk("stray port", 13'h0, {5'h00, q});
    wr('h38, 'hd0);
    rd('h38, "locked write");
    $display("test reset and lock done");
    wr('h13, 'hc5);
    rd('h13, "unlock key");
    h.gap = 2;
    for (int i = 'h37; i <= 'h3c; i++) wr(i, i == 'h37 ? $urandom & 'h3f : $urandom & 'hff);
    foreach (regs[i]) rd(i, "readback");
    h.gap = 0;
    $display("test register traffic done");
    for (int s = 0; s < 16; s++) begin
      wr('h38, (s << 4) | (regs['h38] & 'hf));
      wr('h39, s % 3);
      wr('h3a, 0);
      wr('h3b, 0);
      wr('h37, (regs['h37] & 'h3f) | 'h40);
      t0 = h.t_take;
      expect_rep(s % 3, s, 1, "report kind");
      chk("running on", 13'h1, {12'h000, running});
      wr('h37, regs['h37] & 'h3f);
    end
    rd('h3c, "sticky flag");
    chk("running off", 13'h0, {12'h000, running});
    wr('h3c, 'h20);
    rd('h3c, "restart while off");
    $display("test report kinds done");
    wr('h38, 'hd0 | (regs['h38] & 'hf));
    wr('h39, 3);
    wr('h37, (regs['h37] & 'h3f) | 'h40);
    repeat (2 * TICK) @(posedge mclk);
    wr('h3c, 'h20);
    t0 = h.t_take;
    rd('h3c, "flag after restart");
    expect_rep(3, 13, 0, "restart report");
    wr('h37, regs['h37] & 'h3f);
    $display("test restart done");
    summarize();
  end
endmodule
